// [logic/ceq_pkg.sv]
// shared constants, types and decoders of the conversion enable qualifier
package ceq_pkg;

    // register offsets as seen by the serial command front end
    localparam logic [7:0] ADDR_TURN_ON = 8'h35;
    localparam logic [7:0] ADDR_TURN_OFF = 8'h36;
    localparam logic [7:0] ADDR_PROTO_CFG = 8'hC2;
    localparam logic [7:0] RESET_TURN_ON = 8'h00;
    localparam logic [7:0] RESET_TURN_OFF = 8'h00;
    localparam logic [7:0] RESET_PROTO_CFG = 8'h00;
    localparam logic [7:0] READ_IDLE = 8'h00;

    // field positions
    localparam int ON_SEL_LSB = 0;
    localparam int ON_SEL_MSB = 1;
    localparam int OFF_SEL_LSB = 0;
    localparam int OFF_SEL_MSB = 2;
    localparam int FB_SEL_LSB = 6;
    localparam int FB_SEL_MSB = 7;

    // special codes: combined supply conditions, and the ratio codes that pick the 1:2 divider
    localparam logic [1:0] ON_COMBINED = 2'h3;
    localparam logic [2:0] OFF_COMBINED = 3'h7;
    localparam logic [1:0] FB_HALF_A = 2'h1;
    localparam logic [1:0] FB_HALF_B = 2'h2;

    // threshold levels in units of 100 mV
    localparam logic [6:0] LVL_NONE = 7'h00;
    localparam logic [6:0] LVL_10V0 = 7'h64;
    localparam logic [6:0] LVL_9V0 = 7'h5A;
    localparam logic [6:0] LVL_8V0 = 7'h50;
    localparam logic [6:0] LVL_9V5 = 7'h5F;
    localparam logic [6:0] LVL_8V5 = 7'h55;
    localparam logic [6:0] LVL_7V5 = 7'h4B;
    localparam logic [6:0] LVL_6V5 = 7'h41;
    localparam logic [6:0] LVL_5V5 = 7'h37;
    localparam logic [6:0] LVL_4V2 = 7'h2A;

    // output step and recommended range in mV for both divider ratios
    localparam logic [3:0] STEP_HALF_MV = 4'h5;
    localparam logic [3:0] STEP_QUARTER_MV = 4'hA;
    localparam logic [11:0] VMIN_HALF_MV = 12'h0FA;
    localparam logic [11:0] VMAX_HALF_MV = 12'h5F0;
    localparam logic [11:0] VMIN_QUARTER_MV = 12'h1F4;
    localparam logic [11:0] VMAX_QUARTER_MV = 12'hBE0;

    // enable deglitch time
    localparam real DEGLITCH_US = 0.2;
    localparam int MCLK_MHZ = 200;
    localparam int DEGLITCH_CYCLES = int'($ceil(DEGLITCH_US * real'(MCLK_MHZ)));
    localparam int DGL_CNT_W = 6;
    localparam logic [DGL_CNT_W-1:0] DGL_CNT_LAST =
        DGL_CNT_W'(DEGLITCH_CYCLES - 1);
    localparam logic [DGL_CNT_W-1:0] DGL_CNT_ONE = 6'h01;
    localparam logic [DGL_CNT_W-1:0] DGL_CNT_ZERO = 6'h00;

    // sequencer states, gray coded along lockout, ready, run
    typedef enum logic [1:0]
    {
        SEQ_POR = 2'b00,
        SEQ_READY = 2'b01,
        SEQ_RUN = 2'b11
    } ceq_state_t;

    // turn-on select to level
    function automatic logic [6:0] ceq_on_level(input logic [1:0] sel);
        case (sel)
            2'h0: ceq_on_level = LVL_10V0;
            2'h1: ceq_on_level = LVL_9V0;
            2'h2: ceq_on_level = LVL_8V0;
            default: ceq_on_level = LVL_NONE;
        endcase
    endfunction : ceq_on_level

    // turn-off select to level
    function automatic logic [6:0] ceq_off_level(input logic [2:0] sel);
        case (sel)
            3'h0: ceq_off_level = LVL_4V2;
            3'h1: ceq_off_level = LVL_9V5;
            3'h2: ceq_off_level = LVL_8V5;
            3'h3: ceq_off_level = LVL_7V5;
            3'h4: ceq_off_level = LVL_6V5;
            3'h5: ceq_off_level = LVL_5V5;
            3'h6: ceq_off_level = LVL_4V2;
            default: ceq_off_level = LVL_NONE;
        endcase
    endfunction : ceq_off_level

    // high when the ratio field picks the 1:4 divider
    function automatic logic ceq_fb_quarter(input logic [1:0] sel);
        ceq_fb_quarter = !((sel == FB_HALF_A) || (sel == FB_HALF_B));
    endfunction : ceq_fb_quarter

endpackage : ceq_pkg

// [logic/ceq_deglitch.sv]
// enable pin deglitch filter
`timescale 1ns/1ps
module ceq_deglitch
    import ceq_pkg::*;
(
    input wire logic mclk, // 200 MHz clock
    input wire logic rst_n, // sync reset, active low
    input wire logic rawIn, // enable pin level
    output logic filtered // deglitched level
);

    logic filtered_reg;
    logic [DGL_CNT_W-1:0] cnt_reg;
    logic [DGL_CNT_W-1:0] cnt_next;
    logic differs;
    logic flip;

    // count consecutive samples that disagree with the output
    assign differs = rawIn != filtered_reg;
    assign flip = differs && (cnt_reg == DGL_CNT_LAST);
    assign cnt_next = (differs && !flip) ? cnt_reg + DGL_CNT_ONE
                                         : DGL_CNT_ZERO;
    assign filtered = filtered_reg;

    // reset low, so a floating pin reads as disabled
    always_ff @(posedge mclk)
    begin
        if (!rst_n)
        begin
            filtered_reg <= 1'b0;
            cnt_reg <= DGL_CNT_ZERO;
        end
        else
        begin
            filtered_reg <= filtered_reg ^ flip;
            cnt_reg <= cnt_next;
        end
    end

    // independent run-length of the raw level for checking
    logic [DGL_CNT_W-1:0] runLen;
    always_ff @(posedge mclk)
    begin
        if (!rst_n)
            runLen <= DGL_CNT_ZERO;
        else if (rawIn != $past(rawIn))
            runLen <= DGL_CNT_ONE; // a fresh level counts its first sample
        else if (runLen != DGL_CNT_LAST)
            runLen <= runLen + DGL_CNT_ONE;
    end

    a_glitch_reject: assert property (
        @(posedge mclk) disable iff (!rst_n)
        $changed(filtered_reg) |-> $past(runLen) == DGL_CNT_LAST
                                   && $past(rawIn) == filtered_reg)
        else $error("enable output moved on a short pulse");

    a_float_off: assert property (
        @(posedge mclk)
        !rst_n |=> !filtered_reg [*2])
        else $error("enable not low after reset");

endmodule : ceq_deglitch

// [logic/ceq_conversion_qualifier.sv]
// conversion enable qualifier: lockouts, enable, threshold decode
`timescale 1ns/1ps
module ceq_conversion_qualifier
    import ceq_pkg::*;
(
    input wire logic mclk, // 200 MHz clock
    input wire logic rst_n, // sync reset, active low
    input wire logic biasRiseCmp, // bias above rising lockout level
    input wire logic biasFallCmp, // bias above falling lockout level
    input wire logic biasHighCmp, // bias above combined-mode level
    input wire logic drvRiseCmp, // driver supply above rising level
    input wire logic drvFallCmp, // driver supply above falling level
    input wire logic pwrInOnCmp, // input above selected turn-on level
    input wire logic pwrInOffCmp, // input above selected turn-off level
    input wire logic pwrInLowOnCmp, // input above combined on level
    input wire logic pwrInLowOffCmp, // input above combined off level
    input wire logic enablePin, // board enable pin
    input wire logic [7:0] regAddr, // register offset
    input wire logic regWrEn, // write strobe
    input wire logic [7:0] regWrData, // write data
    input wire logic regRdEn, // read strobe
    output logic [7:0] regRdData, // read data, one cycle later
    output logic regAck, // access accepted
    output logic coreResetN, // digital core out of reset
    output logic i2cEnable, // serial interface allowed
    output logic telemetryEnable, // monitors allowed
    output logic driverEnable, // power FET drivers allowed
    output logic switchEnable, // power stage may switch
    output logic enableFiltered, // deglitched enable
    output logic [6:0] onLevel, // turn-on level, 100 mV units
    output logic onCombined, // turn-on by combined condition
    output logic [6:0] offLevel, // turn-off level, 100 mV units
    output logic offCombined, // turn-off by combined condition
    output logic fbRatioQuarter, // 1 = 1:4 divider, 0 = 1:2
    output logic [3:0] voutStepMv, // output step in mV
    output logic [11:0] voutMinMv, // low end of range in mV
    output logic [11:0] voutMaxMv // high end of range in mV
);

    ceq_state_t state_reg;
    ceq_state_t state_next;
    logic [7:0] onReg_reg;
    logic [7:0] offReg_reg;
    logic [7:0] protoReg_reg;
    logic drvOk_reg;
    logic drvOk_next;
    logic pwrInOk_reg;
    logic pwrInOk_next;
    logic enFilt;
    logic [7:0] rd_reg;
    logic ack_reg;
    logic coreReset_reg;
    logic i2cEn_reg;
    logic telem_reg;
    logic drvEn_reg;
    logic sw_reg;
    logic enOut_reg;
    logic [6:0] onLvl_reg;
    logic onComb_reg;
    logic [6:0] offLvl_reg;
    logic offComb_reg;
    logic fbQ_reg;
    logic [3:0] step_reg;
    logic [11:0] vmin_reg;
    logic [11:0] vmax_reg;

    // enable pin deglitch
    ceq_deglitch u_deglitch
    (
        .mclk(mclk),
        .rst_n(rst_n),
        .rawIn(enablePin),
        .filtered(enFilt)
    );

    // field selection
    logic [1:0] onSel;
    logic [2:0] offSel;
    logic [1:0] fbSel;
    assign onSel = onReg_reg[ON_SEL_MSB:ON_SEL_LSB];
    assign offSel = offReg_reg[OFF_SEL_MSB:OFF_SEL_LSB];
    assign fbSel = protoReg_reg[FB_SEL_MSB:FB_SEL_LSB];

    // input lockout conditions; turn-off wins so a bad setting only chatters
    logic onCond;
    logic offCond;
    assign onCond = (onSel == ON_COMBINED) ? (pwrInLowOnCmp && biasHighCmp)
                                           : pwrInOnCmp;
    assign offCond = (offSel == OFF_COMBINED)
                     ? (!pwrInLowOffCmp || !drvFallCmp)
                     : !pwrInOffCmp;
    assign pwrInOk_next = offCond ? 1'b0
                        : (onCond ? 1'b1 : pwrInOk_reg);

    // driver supply hysteresis
    assign drvOk_next = !drvFallCmp ? 1'b0
                      : (drvRiseCmp ? 1'b1 : drvOk_reg);

    // switching permit needs every lockout clear and the enable high
    logic permit;
    assign permit = drvOk_reg && pwrInOk_reg && enFilt
                    && biasFallCmp;

    // sequencer: a bias drop overrides everything
    always_comb
    begin
        state_next = state_reg;
        case (state_reg)
            SEQ_POR:
                if (biasRiseCmp && biasFallCmp)
                    state_next = SEQ_READY;
            SEQ_READY:
                if (permit)
                    state_next = SEQ_RUN;
            SEQ_RUN:
                if (!permit)
                    state_next = SEQ_READY;
            default:
                state_next = SEQ_POR;
        endcase
        if (!biasFallCmp)
            state_next = SEQ_POR;
    end

    logic coreUp;
    logic coreUpNext;
    assign coreUp = state_reg != SEQ_POR;
    assign coreUpNext = state_next != SEQ_POR;

    // register access decode, open only while the core is up
    logic hitOn;
    logic hitOff;
    logic hitProto;
    logic mapped;
    logic [7:0] rdMux;
    assign hitOn = regAddr == ADDR_TURN_ON;
    assign hitOff = regAddr == ADDR_TURN_OFF;
    assign hitProto = regAddr == ADDR_PROTO_CFG;
    assign mapped = hitOn || hitOff || hitProto;
    assign rdMux = hitOn ? onReg_reg
                 : hitOff ? offReg_reg
                 : hitProto ? protoReg_reg : READ_IDLE;

    // state and lockout flags
    always_ff @(posedge mclk)
    begin
        if (!rst_n)
        begin
            state_reg <= SEQ_POR;
            drvOk_reg <= 1'b0;
            pwrInOk_reg <= 1'b0;
        end
        else
        begin
            state_reg <= state_next;
            drvOk_reg <= drvOk_next;
            pwrInOk_reg <= pwrInOk_next;
        end
    end

    // configuration registers, held at defaults during power-on reset
    always_ff @(posedge mclk)
    begin
        if (!rst_n || !coreUp)
        begin
            onReg_reg <= RESET_TURN_ON;
            offReg_reg <= RESET_TURN_OFF;
            protoReg_reg <= RESET_PROTO_CFG;
        end
        else if (regWrEn && i2cEn_reg)
        begin
            if (hitOn)
                onReg_reg <= regWrData;
            if (hitOff)
                offReg_reg <= regWrData;
            if (hitProto)
                protoReg_reg <= regWrData;
        end
    end

    // read data and acknowledge; unmapped reads give zero, no ack
    always_ff @(posedge mclk)
    begin
        if (!rst_n)
        begin
            rd_reg <= READ_IDLE;
            ack_reg <= 1'b0;
        end
        else
        begin
            rd_reg <= (regRdEn && i2cEn_reg) ? rdMux : READ_IDLE;
            ack_reg <= i2cEn_reg && (regWrEn || regRdEn) && mapped;
        end
    end

    // supply and switching outputs
    always_ff @(posedge mclk)
    begin
        if (!rst_n)
        begin
            coreReset_reg <= 1'b0;
            i2cEn_reg <= 1'b0;
            telem_reg <= 1'b0;
            drvEn_reg <= 1'b0;
            sw_reg <= 1'b0;
            enOut_reg <= 1'b0;
        end
        else
        begin
            coreReset_reg <= coreUpNext;
            i2cEn_reg <= coreUpNext;
            telem_reg <= coreUpNext;
            drvEn_reg <= drvOk_next && coreUpNext;
            sw_reg <= state_next == SEQ_RUN;
            enOut_reg <= enFilt;
        end
    end

    // decoded thresholds and divider settings
    always_ff @(posedge mclk)
    begin
        if (!rst_n)
        begin
            onLvl_reg <= LVL_NONE;
            onComb_reg <= 1'b0;
            offLvl_reg <= LVL_NONE;
            offComb_reg <= 1'b0;
            fbQ_reg <= 1'b1;
            step_reg <= STEP_QUARTER_MV;
            vmin_reg <= VMIN_QUARTER_MV;
            vmax_reg <= VMAX_QUARTER_MV;
        end
        else
        begin
            onLvl_reg <= ceq_on_level(onSel);
            onComb_reg <= onSel == ON_COMBINED;
            offLvl_reg <= ceq_off_level(offSel);
            offComb_reg <= offSel == OFF_COMBINED;
            fbQ_reg <= ceq_fb_quarter(fbSel);
            step_reg <= ceq_fb_quarter(fbSel) ? STEP_QUARTER_MV
                                              : STEP_HALF_MV;
            vmin_reg <= ceq_fb_quarter(fbSel) ? VMIN_QUARTER_MV
                                              : VMIN_HALF_MV;
            vmax_reg <= ceq_fb_quarter(fbSel) ? VMAX_QUARTER_MV
                                              : VMAX_HALF_MV;
        end
    end

    // outputs straight from flops
    assign regRdData = rd_reg;
    assign regAck = ack_reg;
    assign coreResetN = coreReset_reg;
    assign i2cEnable = i2cEn_reg;
    assign telemetryEnable = telem_reg;
    assign driverEnable = drvEn_reg;
    assign switchEnable = sw_reg;
    assign enableFiltered = enOut_reg;
    assign onLevel = onLvl_reg;
    assign onCombined = onComb_reg;
    assign offLevel = offLvl_reg;
    assign offCombined = offComb_reg;
    assign fbRatioQuarter = fbQ_reg;
    assign voutStepMv = step_reg;
    assign voutMinMv = vmin_reg;
    assign voutMaxMv = vmax_reg;

    // named steps for the checks
    sequence s_bias_release;
        !coreResetN && biasRiseCmp && biasFallCmp;
    endsequence
    sequence s_on_write;
        regWrEn && hitOn && i2cEnable;
    endsequence
    sequence s_off_write;
        regWrEn && hitOff && i2cEnable;
    endsequence

    a_bias_lockout: assert property (
        @(posedge mclk) disable iff (!rst_n)
        !biasFallCmp |=> !coreResetN && !i2cEnable)
        else $error("core not held in reset on bias drop");

    a_bias_release: assert property (
        @(posedge mclk) disable iff (!rst_n)
        s_bias_release |=> coreResetN && i2cEnable && !switchEnable)
        else $error("core not released on bias rise");

    a_access_gate: assert property (
        @(posedge mclk) disable iff (!rst_n)
        !i2cEnable |=> !regAck && regRdData == READ_IDLE)
        else $error("register access while locked out");

    a_switch_all: assert property (
        @(posedge mclk) disable iff (!rst_n)
        switchEnable |-> $past(drvOk_reg && pwrInOk_reg && enFilt)
                         && telemetryEnable)
        else $error("switching without all lockouts clear");

    logic drvEnable_chk;
    assign drvEnable_chk = drvRiseCmp && drvFallCmp && biasFallCmp
                           && coreUp;
    a_driver_hyst: assert property (
        @(posedge mclk) disable iff (!rst_n)
        (drvEnable_chk) |=> driverEnable)
        else $error("drivers not enabled above rising level");

    a_bias_stop: assert property (
        @(posedge mclk) disable iff (!rst_n)
        !biasFallCmp |=> !switchEnable ##1 !switchEnable)
        else $error("switching after bias fell");

    a_on_decode: assert property (
        @(posedge mclk) disable iff (!rst_n)
        s_on_write ##1 biasFallCmp |=>
        onLevel == ceq_on_level($past(regWrData[1:0], 2))
        && onCombined == ($past(regWrData[1:0], 2) == ON_COMBINED))
        else $error("turn-on select decoded wrongly");

    a_off_decode: assert property (
        @(posedge mclk) disable iff (!rst_n)
        s_off_write ##1 biasFallCmp |=>
        offLevel == ceq_off_level($past(regWrData[2:0], 2)))
        else $error("turn-off select decoded wrongly");

    a_input_hyst: assert property (
        @(posedge mclk) disable iff (!rst_n)
        offCond |=> !pwrInOk_reg ##1 (!pwrInOk_reg || $past(onCond)))
        else $error("input lockout hysteresis broken");

    a_en_gate: assert property (
        @(posedge mclk) disable iff (!rst_n)
        !enFilt |=> !switchEnable)
        else $error("switching with enable low");

    a_fb_ratio: assert property (
        @(posedge mclk) disable iff (!rst_n)
        ##1 fbRatioQuarter == ceq_fb_quarter($past(fbSel))
        && voutStepMv == (fbRatioQuarter ? STEP_QUARTER_MV : STEP_HALF_MV)
        && voutMaxMv == (fbRatioQuarter ? VMAX_QUARTER_MV : VMAX_HALF_MV))
        else $error("divider ratio settings mismatched");

endmodule : ceq_conversion_qualifier

// [testbench/ceq_conversion_qualifier_test.sv]
// self-checking bench of the conversion enable qualifier
`timescale 1ns/1ps
module ceq_conversion_qualifier_test
    import ceq_pkg::*;
;
    logic mclk, rst_n, biasRiseCmp, biasFallCmp, biasHighCmp;
    logic drvRiseCmp, drvFallCmp, pwrInOnCmp, pwrInOffCmp;
    logic pwrInLowOnCmp, pwrInLowOffCmp, enablePin, regWrEn, regRdEn;
    logic [7:0] regAddr, regWrData, regRdData;
    logic regAck, coreResetN, i2cEnable, telemetryEnable, driverEnable;
    logic switchEnable, enableFiltered, onCombined, offCombined;
    logic fbRatioQuarter;
    logic [6:0] onLevel, offLevel;
    logic [3:0] voutStepMv;
    logic [11:0] voutMinMv, voutMaxMv;
    int n_fail = 0;
    int checks_done = 0;

    ceq_conversion_qualifier u_dut (
        .mclk(mclk), .rst_n(rst_n), .biasRiseCmp(biasRiseCmp),
        .biasFallCmp(biasFallCmp), .biasHighCmp(biasHighCmp),
        .drvRiseCmp(drvRiseCmp), .drvFallCmp(drvFallCmp),
        .pwrInOnCmp(pwrInOnCmp), .pwrInOffCmp(pwrInOffCmp),
        .pwrInLowOnCmp(pwrInLowOnCmp), .pwrInLowOffCmp(pwrInLowOffCmp),
        .enablePin(enablePin), .regAddr(regAddr), .regWrEn(regWrEn),
        .regWrData(regWrData), .regRdEn(regRdEn), .regRdData(regRdData),
        .regAck(regAck), .coreResetN(coreResetN), .i2cEnable(i2cEnable),
        .telemetryEnable(telemetryEnable), .driverEnable(driverEnable),
        .switchEnable(switchEnable), .enableFiltered(enableFiltered),
        .onLevel(onLevel), .onCombined(onCombined), .offLevel(offLevel),
        .offCombined(offCombined), .fbRatioQuarter(fbRatioQuarter),
        .voutStepMv(voutStepMv), .voutMinMv(voutMinMv),
        .voutMaxMv(voutMaxMv)
    );

    // 200 MHz clock
    initial
    begin
        mclk = 1'b0;
        forever #2.5 mclk = ~mclk;
    end

    // inputs always move 1 ns after the edge, so no race with sampling
    task automatic tick(input int n);
        repeat (n) @(posedge mclk);
        #1;
    endtask : tick

    task automatic chk(input logic [11:0] seen, input logic [11:0] exp);
        checks_done++;
        if (seen !== exp)
        begin
            n_fail++;
            $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : chk

    // write strobe for one cycle; ack is due one cycle later
    task automatic wr(input logic [7:0] a, input logic [7:0] d,
        input logic ack);
        regAddr = a;
        regWrData = d;
        regWrEn = 1'b1;
        tick(1);
        regWrEn = 1'b0;
        chk(12'(regAck), 12'(ack));
        tick(1);
    endtask : wr

    task automatic rd(input logic [7:0] a, input logic [7:0] d,
        input logic ack);
        regAddr = a;
        regRdEn = 1'b1;
        tick(1);
        regRdEn = 1'b0;
        chk(12'(regRdData), 12'(d));
        chk(12'(regAck), 12'(ack));
        tick(1);
    endtask : rd

    // lockout flags are registered twice, three edges covers the path
    task automatic sw(input logic e);
        tick(3);
        chk(12'(switchEnable), 12'(e));
    endtask : sw

    task automatic t_lockout;
        wr(ADDR_TURN_ON, 8'h01, 1'b0);
        biasFallCmp = 1'b1;
        tick(3);
        chk(12'(coreResetN), 12'h000);
        biasRiseCmp = 1'b1;
        // released by the very edge that first sees both comparators
        chk(12'(coreResetN), 12'h000);
        tick(1);
        chk(12'(coreResetN), 12'h001);
        chk(12'(i2cEnable), 12'h001);
        chk(12'(telemetryEnable), 12'h001);
        rd(ADDR_TURN_ON, 8'h00, 1'b1);
    endtask : t_lockout

    task automatic t_decode;
        logic [6:0] onExp [4] = '{7'h64, 7'h5A, 7'h50, 7'h00};
        logic [6:0] offExp [8] = '{7'h2A, 7'h5F, 7'h55, 7'h4B,
            7'h41, 7'h37, 7'h2A, 7'h00};
        logic q;
        for (int i = 0; i < 4; i++)
        begin
            wr(ADDR_TURN_ON, 8'(i), 1'b1);
            chk(12'(onLevel), 12'(onExp[i]));
            chk(12'(onCombined), 12'(i == 3));
        end
        for (int i = 0; i < 8; i++)
        begin
            wr(ADDR_TURN_OFF, 8'(i), 1'b1);
            chk(12'(offLevel), 12'(offExp[i]));
            chk(12'(offCombined), 12'(i == 7));
        end
        for (int i = 0; i < 4; i++)
        begin
            wr(ADDR_PROTO_CFG, {2'(i), 6'h00}, 1'b1);
            q = (i == 0) || (i == 3);
            chk(12'(fbRatioQuarter), 12'(q));
            chk(12'(voutStepMv), q ? 12'h00A : 12'h005);
            chk(voutMinMv, q ? 12'h1F4 : 12'h0FA);
            chk(voutMaxMv, q ? 12'hBE0 : 12'h5F0);
        end
        rd(ADDR_PROTO_CFG, 8'hC0, 1'b1);
        rd(ADDR_TURN_OFF, 8'h07, 1'b1);
        wr(8'h37, 8'hFF, 1'b0);
        rd(8'h37, 8'h00, 1'b0);
    endtask : t_decode

    // a 39-cycle pulse must vanish, a held level must pass
    task automatic t_enable;
        enablePin = 1'b1;
        tick(39);
        enablePin = 1'b0;
        tick(45);
        chk(12'(enableFiltered), 12'h000);
        enablePin = 1'b1;
        tick(39);
        chk(12'(enableFiltered), 12'h000);
        tick(3);
        chk(12'(enableFiltered), 12'h001);
    endtask : t_enable

    task automatic t_switch;
        {drvRiseCmp, drvFallCmp, pwrInOnCmp, pwrInOffCmp} = 4'hF;
        {pwrInLowOnCmp, pwrInLowOffCmp, biasHighCmp} = 3'h7;
        // software keeps turn-on (10 V) above turn-off (4.2 V)
        wr(ADDR_TURN_ON, 8'h00, 1'b1);
        wr(ADDR_TURN_OFF, 8'h00, 1'b1);
        sw(1'b1);
        chk(12'(driverEnable), 12'h001);
        drvRiseCmp = 1'b0;
        sw(1'b1);
        drvFallCmp = 1'b0;
        sw(1'b0);
        chk(12'(driverEnable), 12'h000);
        drvFallCmp = 1'b1;
        sw(1'b0);
        drvRiseCmp = 1'b1;
        sw(1'b1);
        pwrInOnCmp = 1'b0;
        sw(1'b1);
        pwrInOffCmp = 1'b0;
        sw(1'b0);
        pwrInOffCmp = 1'b1;
        sw(1'b0);
        pwrInOnCmp = 1'b1;
        sw(1'b1);
        // combined codes ignore the selected-level comparators
        wr(ADDR_TURN_ON, 8'h03, 1'b1);
        wr(ADDR_TURN_OFF, 8'h07, 1'b1);
        pwrInLowOffCmp = 1'b0;
        sw(1'b0);
        pwrInLowOffCmp = 1'b1;
        biasHighCmp = 1'b0;
        sw(1'b0);
        biasHighCmp = 1'b1;
        sw(1'b1);
        drvFallCmp = 1'b0;
        sw(1'b0);
        drvFallCmp = 1'b1;
        sw(1'b1);
        biasFallCmp = 1'b0;
        tick(2);
        chk(12'(switchEnable), 12'h000);
        chk(12'(coreResetN), 12'h000);
        biasFallCmp = 1'b1;
        tick(3);
        rd(ADDR_TURN_ON, 8'h00, 1'b1);
        sw(1'b1);
        enablePin = 1'b0;
        tick(42);
        sw(1'b0);
    endtask : t_switch

    task automatic summarize;
        $display("checks=%0d failures=%0d", checks_done, n_fail);
        if (n_fail == 0 && checks_done > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask : summarize

    // watchdog well beyond the roughly 290 cycles of stimulus
    initial
    begin
        repeat (5000) @(posedge mclk);
        n_fail++;
        summarize();
    end

    initial
    begin
        {rst_n, biasRiseCmp, biasFallCmp, biasHighCmp} = 4'h0;
        {drvRiseCmp, drvFallCmp, pwrInOnCmp, pwrInOffCmp} = 4'h0;
        {pwrInLowOnCmp, pwrInLowOffCmp, enablePin} = 3'h0;
        {regWrEn, regRdEn, regAddr, regWrData} = 18'h00000;
        tick(6);
        chk(12'(fbRatioQuarter), 12'h001);
        rst_n = 1'b1;
        tick(2);
        chk(12'(enableFiltered), 12'h000);
        chk(12'(switchEnable), 12'h000);
        t_lockout();
        t_decode();
        t_enable();
        t_switch();
        summarize();
    end
endmodule : ceq_conversion_qualifier_test
